// ==== hw/flash_seq.sv ====
/*
 * flash program/erase sequencer with ecc-protected byte reads behind an axi4-lite slave.
 * assumes one clock, active-low async reset; array modelled by an internal memory.
 */
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module flash_seq
   import flash_seq_pkg::*;
#(
   parameter int PROG_CNT  = PROG_CYCLES,
   parameter int ERASE_CNT = ERASE_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // axi4-lite write
   input  wire logic [7:0]  s_awaddr,
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   output logic [1:0]       s_bresp,
   output logic             s_bvalid,
   input  wire logic        s_bready,
   // axi4-lite read
   input  wire logic [7:0]  s_araddr,
   input  wire logic        s_arvalid,
   output logic             s_arready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   // interrupt on any unmasked status: erase completion, refusal or ecc correction
   output logic             irq
);

   // ***********************************************
   // array storage with per-byte hamming check bits
   // ***********************************************
   localparam int CELLS = NUM_WORDLINES * WL_BYTES;
   logic [7:0] mem_data [CELLS];
   logic [4:0] mem_chk  [CELLS];

   function automatic logic [4:0] ecc_gen(input logic [7:0] d);
      logic [4:0] c;
      c[0] = d[0] ^ d[1] ^ d[3] ^ d[4] ^ d[6];
      c[1] = d[0] ^ d[2] ^ d[3] ^ d[5] ^ d[6];
      c[2] = d[1] ^ d[2] ^ d[3] ^ d[7];
      c[3] = d[4] ^ d[5] ^ d[6] ^ d[7];
      c[4] = ^d;
      return c;
   endfunction

   // syndrome position of each data bit in the hamming code
   function automatic logic [7:0] ecc_fix(input logic [7:0] d, input logic [4:0] c);
      logic [4:0] s;
      logic [3:0] p;
      logic [7:0] o;
      s = ecc_gen(d) ^ c;
      p = s[3:0];
      o = d;
      case (p)
         4'h3:    o[0] = ~d[0];
         4'h5:    o[1] = ~d[1];
         4'h6:    o[2] = ~d[2];
         4'h7:    o[3] = ~d[3];
         4'h9:    o[4] = ~d[4];
         4'ha:    o[5] = ~d[5];
         4'hb:    o[6] = ~d[6];
         4'hc:    o[7] = ~d[7];
         default: o = d;
      endcase
      return o;
   endfunction

   // ***********************************************
   // registers
   // ***********************************************
   logic [ADDR_W-1:0]      addr_r;
   logic [NUM_SECTORS-1:0] sector_r;
   logic [7:0]             wbuf_r [WL_BYTES];
   logic [7:0]             rdata_r;
   logic [2:0]             irq_stat_r;
   logic [2:0]             mask_r;
   logic                   not_started_r;
   op_t                    op_r;
   logic [31:0]            cnt_r;
   logic [1:0]             rd_cnt_r;
   logic                   rd_busy_r;
   logic                   ecc_hit;
   status_t                stat;

   // ***********************************************
   // axi4-lite slave
   // ***********************************************
   logic aw_hold_r, w_hold_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic        wr_go;

   assign wr_go = aw_hold_r && w_hold_r && !s_bvalid;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0000_0000;
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
         s_bvalid  <= 1'b0;
         s_bresp   <= RESP_OKAY;
      end else begin
         s_awready <= !aw_hold_r && !s_awready && s_awvalid;
         s_wready  <= !w_hold_r && !s_wready && s_wvalid;
         if (s_awready && s_awvalid) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_awaddr;
         end
         if (s_wready && s_wvalid) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_wdata;
         end
         if (wr_go) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            s_bvalid  <= 1'b1;
            s_bresp   <= (awaddr_r == WDATA_OFS || (awaddr_r > MASK_OFS && awaddr_r[7:5] != 3'h1))
                         ? RESP_SLVERR : RESP_OKAY;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end

   // write decodes
   logic wr_ctrl, wr_addr, wr_sect, wr_irq, wr_mask, wr_wbuf;
   assign wr_ctrl = wr_go && awaddr_r == CTRL_OFS;
   assign wr_addr = wr_go && awaddr_r == ADDR_OFS;
   assign wr_sect = wr_go && awaddr_r == SECTOR_OFS;
   assign wr_irq  = wr_go && awaddr_r == IRQ_OFS;
   assign wr_mask = wr_go && awaddr_r == MASK_OFS;
   // word_line buffer at 0x20..0x3f, one aligned word fills four bytes, low byte first
   assign wr_wbuf = wr_go && awaddr_r[7:5] == 3'h1;

   logic req_prog, req_erase, req_abort, req_read, active;
   assign active    = op_r != OP_IDLE;
   assign req_prog  = wr_ctrl && wdata_r[CTRL_PROG_BIT];
   assign req_erase = wr_ctrl && wdata_r[CTRL_ERASE_BIT];
   assign req_abort = wr_ctrl && wdata_r[CTRL_ABORT_BIT];
   assign req_read  = wr_ctrl && wdata_r[CTRL_READ_BIT];

   // ***********************************************
   // configuration registers
   // ***********************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         addr_r   <= '0;
         sector_r <= '0;
         mask_r   <= MASK_RST;
      end else begin
         // full byte address stored; programming uses only its word_line bits above WL_ADDR_LSB
         if (wr_addr) addr_r <= wdata_r[ADDR_W-1:0];
         if (wr_sect) sector_r <= wdata_r[NUM_SECTORS-1:0];
         // bit 0 doubles as the completion nmi enable
         if (wr_mask) mask_r <= wdata_r[2:0];
      end
   end

   always_ff @(posedge clk) begin
      if (wr_wbuf) begin
         for (int j = 0; j < 4; j++) begin
            wbuf_r[{awaddr_r[4:2], 2'(j)}] <= wdata_r[8*j +: 8];
         end
      end
   end

   // ***********************************************
   // program / erase sequencer
   // ***********************************************
   logic refuse, done_ev, erase_ok;
   // any busy operation or an empty erase bitmap refuses the request
   assign refuse   = (req_prog || req_erase) && (active || rd_busy_r);
   assign erase_ok = req_erase && !refuse && sector_r != '0;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         op_r          <= OP_IDLE;
         cnt_r         <= '0;
         not_started_r <= 1'b0;
      end else begin
         case (op_r)
            OP_IDLE: begin
               if (req_prog && !refuse) begin
                  op_r          <= OP_PROG;
                  cnt_r         <= 32'(PROG_CNT - 1);
                  not_started_r <= 1'b0;
               end else if (req_erase) begin
                  not_started_r <= !erase_ok;
                  if (erase_ok) begin
                     op_r  <= OP_ERASE;
                     cnt_r <= 32'(ERASE_CNT - 1);
                  end
               end else if (req_prog) begin
                  not_started_r <= 1'b1;
               end
            end
            OP_PROG, OP_ERASE: begin
               if (refuse) not_started_r <= 1'b1;
               if (op_r == OP_ERASE && req_abort) begin
                  op_r <= OP_IDLE;
               end else if (cnt_r == 32'h0) begin
                  op_r <= OP_IDLE;
               end else begin
                  cnt_r <= cnt_r - 32'h1;
               end
            end
            default: op_r <= OP_IDLE;
         endcase
      end
   end

   assign done_ev = op_r == OP_ERASE && cnt_r == 32'h0 && !req_abort;

   // array update at completion: whole word_line or whole sectors
   localparam int SECT_CELLS = CELLS / 8;
   always_ff @(posedge clk) begin
      if (op_r == OP_PROG && cnt_r == 32'h0) begin
         for (int i = 0; i < WL_BYTES; i++) begin
            // cells only move toward one, so zeros in a second pass keep old bytes
            mem_data[{addr_r[ADDR_W-1:WL_ADDR_LSB], 5'(i)}] <=
               mem_data[{addr_r[ADDR_W-1:WL_ADDR_LSB], 5'(i)}] | wbuf_r[i];
            mem_chk[{addr_r[ADDR_W-1:WL_ADDR_LSB], 5'(i)}] <=
               ecc_gen(mem_data[{addr_r[ADDR_W-1:WL_ADDR_LSB], 5'(i)}] | wbuf_r[i]);
         end
      end else if (done_ev) begin
         for (int c = 0; c < CELLS; c++) begin
            if (sector_r[c / SECT_CELLS]) begin
               mem_data[c] <= 8'h00;
               mem_chk[c]  <= ecc_gen(8'h00);
            end
         end
      end
   end

   // ***********************************************
   // byte read, paced at one core_clock per cycle group
   // ***********************************************
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_busy_r <= 1'b0;
         rd_cnt_r  <= 2'h0;
         rdata_r   <= 8'h00;
      end else if (req_read && !rd_busy_r && op_r != OP_ERASE) begin
         rd_busy_r <= 1'b1;
         rd_cnt_r  <= 2'(READ_CYCLES - 1);
      end else if (rd_busy_r) begin
         if (rd_cnt_r == 2'h0) begin
            rd_busy_r <= 1'b0;
            rdata_r   <= ecc_fix(mem_data[addr_r], mem_chk[addr_r]);
         end else begin
            rd_cnt_r <= rd_cnt_r - 2'h1;
         end
      end
   end

   assign ecc_hit = rd_busy_r && rd_cnt_r == 2'h0
                    && ecc_gen(mem_data[addr_r]) != mem_chk[addr_r];

   // ***********************************************
   // sticky interrupt status, write one to clear
   // ***********************************************
   logic [2:0] ev;
   assign ev = {ecc_hit, refuse || (req_erase && !erase_ok && !active), done_ev};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_stat_r <= 3'h0;
         irq        <= 1'b0;
      end else begin
         // set wins over clear
         irq_stat_r <= (irq_stat_r & ~(wr_irq ? wdata_r[2:0] : 3'h0)) | ev;
         irq        <= |(((irq_stat_r & ~(wr_irq ? wdata_r[2:0] : 3'h0)) | ev)
                         & (wr_mask ? wdata_r[2:0] : mask_r));
      end
   end

   // ***********************************************
   // read channel
   // ***********************************************
   assign stat = '{busy: active, read_busy: rd_busy_r, not_started: not_started_r,
                   op: op_r};

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0000_0000;
         s_rresp   <= RESP_OKAY;
      end else begin
         s_arready <= !s_arready && !s_rvalid && s_arvalid;
         if (s_arready && s_arvalid) begin
            s_rvalid <= 1'b1;
            s_rresp  <= RESP_OKAY;
            case (s_araddr)
               CTRL_OFS:   s_rdata <= 32'h0;
               STATUS_OFS: s_rdata <= {27'h0, stat};
               ADDR_OFS:   s_rdata <= {20'h0, addr_r};
               SECTOR_OFS: s_rdata <= {22'h0, sector_r};
               RDATA_OFS:  s_rdata <= {24'h0, rdata_r};
               IRQ_OFS:    s_rdata <= {29'h0, irq_stat_r};
               MASK_OFS:   s_rdata <= {29'h0, mask_r};
               default: begin
                  s_rdata <= 32'h0;
                  s_rresp <= RESP_SLVERR;
               end
            endcase
         end else if (s_rvalid && s_rready) begin
            s_rvalid <= 1'b0;
         end
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   refuse_keeps_op_a: assert property (@(posedge clk) disable iff (!reset_n)
      (active && req_prog) |=> op_r == $past(op_r) || $past(cnt_r) == 32'h0)
      else $error("running operation disturbed by refused request");
   abort_stops_a: assert property (@(posedge clk) disable iff (!reset_n)
      (op_r == OP_ERASE && req_abort) |=> op_r == OP_IDLE && !irq_stat_r[IRQ_DONE_BIT]
      || $past(irq_stat_r[IRQ_DONE_BIT]))
      else $error("erase not aborted");
   erase_status_a: assert property (@(posedge clk) disable iff (!reset_n)
      (!active && req_erase) |=> not_started_r == (op_r != OP_ERASE))
      else $error("erase status wrong");
   done_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
      done_ev |=> irq_stat_r[IRQ_DONE_BIT] && op_r == OP_IDLE)
      else $error("done flag not set");
   read_blocked_a: assert property (@(posedge clk) disable iff (!reset_n)
      (op_r == OP_ERASE && !rd_busy_r) |=> !rd_busy_r)
      else $error("read started during erase");
   read_time_a: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(rd_busy_r) |-> rd_busy_r [*3] ##1 !rd_busy_r)
      else $error("read not three cycles");
   nmi_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      (irq_stat_r[IRQ_DONE_BIT] && !mask_r[IRQ_DONE_BIT]
       && (irq_stat_r[2:1] & mask_r[2:1]) == 2'h0) |-> !irq)
      else $error("completion interrupt not suppressed");
   prog_len_a: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(op_r == OP_PROG) |-> cnt_r == 32'(PROG_CNT - 1))
      else $error("program length wrong");

endmodule

// ==== hw/flash_seq_pkg.sv ====
/*
 * constants, register map and carrier types for the flash program/erase sequencer.
 * assumes an axi4-lite master on the system clock; the array is an internal memory of flash_seq.
 */
package flash_seq_pkg;

   // ***********************************************
   // geometry
   // ***********************************************
   localparam int WL_BYTES      = 32;
   localparam int WL_ADDR_LSB   = 5;
   localparam int NUM_SECTORS   = 10;
   localparam int ADDR_W        = 12;
   localparam int NUM_WORDLINES = 128;

   // ***********************************************
   // timing
   // ***********************************************
   localparam int PROG_CYCLES  = 209440;
   localparam int ERASE_CYCLES = 8175360;
   localparam int READ_CYCLES  = 3;
   localparam int CLK_MHZ      = 25;
   localparam int CORE_CLOCK_DIV     = 3;

   // ***********************************************
   // register offsets
   // ***********************************************
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] ADDR_OFS   = 8'h08;
   localparam logic [7:0] SECTOR_OFS = 8'h0c;
   localparam logic [7:0] WDATA_OFS  = 8'h10;
   localparam logic [7:0] RDATA_OFS  = 8'h14;
   localparam logic [7:0] IRQ_OFS    = 8'h18;
   localparam logic [7:0] MASK_OFS   = 8'h1c;

   // ctrl fields (write one to trigger)
   localparam int CTRL_PROG_BIT  = 0;
   localparam int CTRL_ERASE_BIT = 1;
   localparam int CTRL_ABORT_BIT = 2;
   localparam int CTRL_READ_BIT  = 3;
   // irq fields
   localparam int IRQ_DONE_BIT   = 0;
   localparam int IRQ_REFUSE_BIT = 1;
   localparam int IRQ_ECC_BIT    = 2;

   localparam logic [2:0]  MASK_RST   = 3'h0;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {OP_IDLE, OP_PROG, OP_ERASE} op_t;

   typedef struct packed {
      logic        busy;
      logic        read_busy;
      logic        not_started;
      logic [1:0]  op;
   } status_t;

endpackage

// ==== tb/flash_cpu_model.sv ====
/*
 * requester model: axi4-lite master tasks on behalf of the cpu.
 * assumes callers enter each task just after a rising clock edge.
 */
`timescale 1ns/1ps
module flash_cpu_model (
   // clock
   input  wire logic        clk,
   // write channels
   output logic [7:0]       awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   // read channels
   output logic [7:0]       araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
      wstrb = 4'hf;
   end

   // address and data offered together, each released when taken
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge clk);
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge clk);
   endtask
endmodule

// ==== tb/flash_program_erase_sequencer_tb_top.sv ====
/*
 * self-checking bench for the flash sequencer, short op counts.
 * assumes the cpu model drives the register bus.
 */
`timescale 1ns/1ps
module flash_program_erase_sequencer_tb_top;
   import flash_seq_pkg::*;
   localparam int P_CNT = 20;
   localparam int E_CNT = 40;
   localparam int LIMIT = 20000;
   logic        clk, reset_n, irq;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic [7:0]  b;
   int          bad_count, n_checks, cyc;

   flash_seq #(.PROG_CNT(P_CNT), .ERASE_CNT(E_CNT)) u_flash_seq (
      .clk(clk), .reset_n(reset_n), .s_awaddr(awaddr), .s_awvalid(awvalid),
      .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb), .s_wvalid(wvalid),
      .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
      .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
      .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .irq(irq));

   flash_cpu_model u_flash_cpu_model (
      .clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // ***********************************************
   // helpers
   // ***********************************************
   task automatic end_sim;
      $display("checks %0d errors %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      u_flash_cpu_model.bus_wr(a, v, r);
   endtask

   task automatic rd(input logic [7:0] a);
      u_flash_cpu_model.bus_rd(a, d, r);
   endtask

   task automatic wait_idle;
      for (int i = 0; i < 100; i++) begin
         rd(STATUS_OFS);
         if (d[4:3] === 2'h0) break;
      end
      chk("busy", {30'h0, d[4:3]}, 32'h0);
   endtask

   task automatic fread(input logic [11:0] a);
      wr(ADDR_OFS, {20'h0, a});
      wr(CTRL_OFS, 32'h8);
      wait_idle();
      rd(RDATA_OFS);
      b = d[7:0];
   endtask

   task automatic prog(input logic [11:0] a, input logic [31:0] w0, w1, rest);
      wr(ADDR_OFS, {20'h0, a});
      for (int i = 0; i < 8; i++) wr(8'h20 + 8'(4 * i), (i == 0) ? w0 : (i == 1) ? w1 : rest);
      wr(CTRL_OFS, 32'h1);
      rd(STATUS_OFS);
      chk("prog busy", {28'h0, d[4], d[2:0]}, 32'h9);
      wr(CTRL_OFS, 32'h2);
      rd(STATUS_OFS);
      chk("refused op", {29'h0, d[2:0]}, 32'h5);
      wait_idle();
   endtask

   // ***********************************************
   // scenarios
   // ***********************************************
   task automatic t_reset_map;
      rd(STATUS_OFS);
      chk("status rst", d, 32'h0);
      rd(MASK_OFS);
      chk("mask rst", d, 32'h0);
      rd(IRQ_OFS);
      chk("irq rst", d, 32'h0);
      rd(8'h10);
      chk("unmapped rd", {30'h0, r}, {30'h0, RESP_SLVERR});
      rd(8'h20);
      chk("buffer rd", {30'h0, r}, {30'h0, RESP_SLVERR});
      wr(8'h10, 32'h1);
      chk("unmapped wr", {30'h0, r}, {30'h0, RESP_SLVERR});
   endtask

   task automatic t_erase_all;
      wr(SECTOR_OFS, 32'h3ff);
      wr(CTRL_OFS, 32'h2);
      rd(STATUS_OFS);
      chk("erase start", {29'h0, d[4], d[2], 1'b0}, 32'h4);
      wr(CTRL_OFS, 32'h8);
      rd(STATUS_OFS);
      chk("read denied", {31'h0, d[3]}, 32'h0);
      wr(CTRL_OFS, 32'h2);
      rd(STATUS_OFS);
      chk("busy refusal", {31'h0, d[2]}, 32'h1);
      wait_idle();
      rd(IRQ_OFS);
      chk("done flag", d, 32'h3);
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(MASK_OFS, 32'h1);
      @(posedge clk);
      chk("irq enabled", {31'h0, irq}, 32'h1);
      wr(IRQ_OFS, 32'h3);
      @(posedge clk);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      rd(IRQ_OFS);
      chk("flag cleared", d, 32'h0);
      fread(12'h020);
      chk("erased s0", {24'h0, b}, 32'h0);
      fread(12'he00);
      chk("erased s7", {24'h0, b}, 32'h0);
   endtask

   task automatic t_program;
      prog(12'h020, 32'h5a5a5a5a, 32'h0, 32'ha5a5a5a5);
      fread(12'h020);
      chk("pass1 b0", {24'h0, b}, 32'h5a);
      fread(12'h024);
      chk("pass1 b4", {24'h0, b}, 32'h0);
      fread(12'h03f);
      chk("pass1 b31", {24'h0, b}, 32'ha5);
      prog(12'h020, 32'h0, 32'hc3c3c3c3, 32'h0);
      fread(12'h024);
      chk("pass2 b4", {24'h0, b}, 32'hc3);
      fread(12'h020);
      chk("pass2 b0", {24'h0, b}, 32'h5a);
      prog(12'h200, 32'h11111111, 32'h0, 32'h0);
      fread(12'h200);
      chk("s1 prog", {24'h0, b}, 32'h11);
   endtask

   task automatic t_sector;
      wr(IRQ_OFS, 32'h7);
      wr(SECTOR_OFS, 32'h2);
      wr(CTRL_OFS, 32'h2);
      wait_idle();
      fread(12'h200);
      chk("s1 erased", {24'h0, b}, 32'h0);
      fread(12'h024);
      chk("s0 kept", {24'h0, b}, 32'hc3);
      wr(SECTOR_OFS, 32'h0);
      wr(CTRL_OFS, 32'h2);
      rd(STATUS_OFS);
      chk("empty map", {31'h0, d[2]}, 32'h1);
   endtask

   task automatic t_abort;
      wr(IRQ_OFS, 32'h7);
      wr(SECTOR_OFS, 32'h1);
      wr(CTRL_OFS, 32'h2);
      wr(CTRL_OFS, 32'h4);
      rd(STATUS_OFS);
      chk("aborted", {31'h0, d[4]}, 32'h0);
      repeat (E_CNT) @(posedge clk);
      rd(IRQ_OFS);
      chk("no done", {31'h0, d[0]}, 32'h0);
   endtask

   // ***********************************************
   // run control
   // ***********************************************
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         bad_count++;
         end_sim();
      end
   end

   initial begin
      reset_n = 1'b0;
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      t_reset_map();
      t_erase_all();
      t_program();
      t_sector();
      t_abort();
      end_sim();
   end
endmodule
